// [inc/dacpl_pkg.sv]
// Shared types and constants of the converter load port controller
package dacpl_pkg;

	// Word width of the converter load port and width of the phase timer
	localparam int DATA_W     = 12;
	localparam int CNT_W      = 8;

	// Clock rate and strobe timing
	localparam int CLK_HZ     = 20_000_000;
	localparam int CLK_NS     = 1_000_000_000 / CLK_HZ;
	localparam int T_SETUP_NS = 50;
	localparam int T_LOW_NS   = 100;
	localparam int T_HOLD_NS  = 50;
	localparam int T_TURN_NS  = 50;
	localparam int SETUP_CYC  = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOW_CYC    = (T_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC   = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int TURN_CYC   = (T_TURN_NS + CLK_NS - 1) / CLK_NS;

	// Reset values
	localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
	localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;

	// User request towards the controller
	typedef struct packed {
		logic              valid;
		logic              wr;
		logic [DATA_W-1:0] data;
	} dacpl_req_t;

	// Pin drive towards the converter
	typedef struct packed {
		logic              cs_n;
		logic              rw;
		logic [DATA_W-1:0] db_out;
		logic              db_oe;
	} dacpl_pins_t;

	localparam dacpl_pins_t PINS_RST = '{cs_n: 1'b1, rw: 1'b1,
		db_out: DATA_RST, db_oe: 1'b0};

	// Sequencer states
	typedef enum logic [2:0] {
		DACPL_IDLE,
		DACPL_W_SETUP,
		DACPL_W_LOW,
		DACPL_W_HOLD,
		DACPL_R_SETUP,
		DACPL_R_LOW,
		DACPL_R_TURN
	} dacpl_state_t;

endpackage : dacpl_pkg

// [design/dacpl_timer.sv]
// Loadable down counter that paces the strobe phases
module dacpl_timer #(
	parameter int W = 8
) (
	// Clock, reset and enable
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         ce,
	// Load and status
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              zero
);

	typedef struct packed {
		logic [W-1:0] count;
	} dacpl_tmr_t;

	dacpl_tmr_t tmr;
	dacpl_tmr_t next_tmr;

	// Load or count down to zero and stay there
	always_comb begin
		next_tmr = tmr;
		if (load) begin
			next_tmr.count = load_val;
		end else if (tmr.count != '0) begin
			next_tmr.count = tmr.count - W'(1);
		end
	end

	// State register, frozen while the enable is low
	always_ff @(posedge mclk) begin
		if (rst) begin
			tmr <= '0;
		end else if (ce) begin
			tmr <= next_tmr;
		end
	end

	assign zero = (tmr.count == '0);

endmodule : dacpl_timer

// [design/dacpl_host.sv]
// Controller that writes and reads back a parallel-load converter port
// Functional notes
// - Every load moves one full 12-bit word
// - Write: select and direction low, data driven
// - Each write needs falling then rising select
// - Read: direction high, select low, sample bus
module dacpl_host
	import dacpl_pkg::*;
#(
	parameter int SETUP_N = dacpl_pkg::SETUP_CYC,
	parameter int LOW_N   = dacpl_pkg::LOW_CYC,
	parameter int HOLD_N  = dacpl_pkg::HOLD_CYC,
	parameter int TURN_N  = dacpl_pkg::TURN_CYC
) (
	// Clock, reset and enable
	input  wire logic                         mclk,
	input  wire logic                         rst,
	input  wire logic                         ce,
	// User request side
	input  wire dacpl_pkg::dacpl_req_t        req,
	output logic                              req_ready,
	output logic                              rsp_valid,
	output logic [dacpl_pkg::DATA_W-1:0]      rsp_data,
	// Converter pins
	output dacpl_pkg::dacpl_pins_t            pins,
	input  wire logic [dacpl_pkg::DATA_W-1:0] db_in
);

	import dacpl_pkg::*;

	// Whole state of the controller
	typedef struct packed {
		dacpl_state_t      st;
		dacpl_pins_t       pins;
		logic              req_ready;
		logic              rsp_valid;
		logic [DATA_W-1:0] rsp_data;
	} dacpl_host_t;

	dacpl_host_t       s;
	dacpl_host_t       next_s;
	logic              tmr_load;
	logic [CNT_W-1:0]  tmr_val;
	logic              tmr_zero;
	logic              accept;

	// A request is taken only from the idle state
	assign accept = req.valid && s.req_ready && (s.st == DACPL_IDLE);

	// Phase timer shared by all strobe phases
	dacpl_timer #(
		.W        (CNT_W)
	) u_timer (
		.mclk     (mclk),
		.rst      (rst),
		.ce       (ce),
		.load     (tmr_load),
		.load_val (tmr_val),
		.zero     (tmr_zero)
	);

	// Sequencer for write and read strobes
	always_comb begin
		next_s = s;
		next_s.rsp_valid = 1'b0;
		tmr_load = 1'b0;
		tmr_val = CNT_RST;
		case (s.st)
			DACPL_IDLE: begin
				if (!s.req_ready) begin
					// First enabled cycle after reset opens the port
					next_s.req_ready = 1'b1;
				end else if (accept && req.wr) begin
					// Whole word presented at once, select still high
					next_s.pins.db_out = req.data;
					next_s.pins.db_oe = 1'b1;
					next_s.pins.rw = 1'b0;
					next_s.req_ready = 1'b0;
					next_s.st = DACPL_W_SETUP;
					tmr_load = 1'b1;
					tmr_val = CNT_W'(SETUP_N - 1);
				end else if (accept) begin
					// Bus released in the same cycle that direction turns to read
					next_s.pins.db_oe = 1'b0;
					next_s.pins.rw = 1'b1;
					next_s.req_ready = 1'b0;
					next_s.st = DACPL_R_SETUP;
					tmr_load = 1'b1;
					tmr_val = CNT_W'(TURN_N - 1);
				end
			end
			DACPL_W_SETUP: begin
				if (tmr_zero) begin
					next_s.pins.cs_n = 1'b0;
					next_s.st = DACPL_W_LOW;
					tmr_load = 1'b1;
					tmr_val = CNT_W'(LOW_N - 1);
				end
			end
			DACPL_W_LOW: begin
				if (tmr_zero) begin
					// Rising select loads the converter; data still held
					next_s.pins.cs_n = 1'b1;
					next_s.st = DACPL_W_HOLD;
					tmr_load = 1'b1;
					tmr_val = CNT_W'(HOLD_N - 1);
				end
			end
			DACPL_W_HOLD: begin
				if (tmr_zero) begin
					next_s.pins.db_oe = 1'b0;
					next_s.pins.rw = 1'b1;
					next_s.rsp_valid = 1'b1;
					next_s.rsp_data = s.pins.db_out;
					next_s.req_ready = 1'b1;
					next_s.st = DACPL_IDLE;
				end
			end
			DACPL_R_SETUP: begin
				if (tmr_zero) begin
					next_s.pins.cs_n = 1'b0;
					next_s.st = DACPL_R_LOW;
					tmr_load = 1'b1;
					tmr_val = CNT_W'(LOW_N - 1);
				end
			end
			DACPL_R_LOW: begin
				if (tmr_zero) begin
					// Sample the read-back word as select rises
					next_s.rsp_data = db_in;
					next_s.rsp_valid = 1'b1;
					next_s.pins.cs_n = 1'b1;
					next_s.st = DACPL_R_TURN;
					tmr_load = 1'b1;
					tmr_val = CNT_W'(TURN_N - 1);
				end
			end
			DACPL_R_TURN: begin
				// Device lets go of the bus before the next drive
				if (tmr_zero) begin
					next_s.req_ready = 1'b1;
					next_s.st = DACPL_IDLE;
				end
			end
			default: begin
				next_s.st = DACPL_IDLE;
				next_s.pins = PINS_RST;
				next_s.req_ready = 1'b1;
			end
		endcase
	end

	// State register, frozen while the enable is low
	always_ff @(posedge mclk) begin
		if (rst) begin
			s.st <= DACPL_IDLE;
			s.pins <= PINS_RST;
			s.req_ready <= 1'b0;
			s.rsp_valid <= 1'b0;
			s.rsp_data <= DATA_RST;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign pins = s.pins;
	assign req_ready = s.req_ready;
	assign rsp_valid = s.rsp_valid;
	assign rsp_data = s.rsp_data;

	// Bounds for the strobe checks
	localparam int A_FALL_MAX = 32;
	localparam int A_RISE_MAX = 64;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst || !ce);

	// Write strobe: select falls with direction low, then rises
	sequence s_w_fall;
		$fell(pins.cs_n) && !pins.rw && pins.db_oe;
	endsequence

	sequence s_w_rise;
		$rose(pins.cs_n) && !pins.rw && pins.db_oe;
	endsequence

	a_write_strobe: assert property (
		accept && req.wr |-> ##[1:A_FALL_MAX] s_w_fall
			##[1:A_RISE_MAX] s_w_rise)
		else $error("write lacks a full select low-high cycle");

	a_write_word: assert property (
		accept && req.wr |=> pins.db_oe && pins.db_out == $past(req.data))
		else $error("write word not driven whole");

	a_write_drive: assert property (
		!pins.cs_n && !pins.rw |-> pins.db_oe && $stable(pins.db_out))
		else $error("data not held while write select is low");

	a_read_release: assert property (
		!pins.cs_n && pins.rw |-> !pins.db_oe)
		else $error("bus driven during read window");

	a_dir_stable: assert property (
		!pins.cs_n && !$fell(pins.cs_n) |-> $stable(pins.rw))
		else $error("direction changed while selected");

	a_read_sample: assert property (
		$rose(pins.cs_n) && pins.rw |-> rsp_valid
			&& rsp_data == $past(db_in))
		else $error("read word not taken at select rise");

	a_oe_start: assert property (
		$rose(pins.db_oe) |-> pins.cs_n && !pins.rw)
		else $error("drive began with select low or read direction");

endmodule : dacpl_host

// [bench/dacpl_dev_model.sv]
// Behavioural model of the parallel-load converter port
module dacpl_dev_model
	import dacpl_pkg::*;
(
	// Strobes and bus from the host
	input  wire logic              cs_n,
	input  wire logic              rw,
	input  wire logic [DATA_W-1:0] db_out,
	input  wire logic              db_oe,
	// Bus level and observed state
	output logic      [DATA_W-1:0] db_in,
	output logic      [DATA_W-1:0] conv_reg,
	output logic                   clash
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [DATA_W-1:0] in_reg = 12'h000;
	logic [DATA_W-1:0] last   = 12'h000;
	wire               drv    = !cs_n && rw;

	initial conv_reg = 12'h000;
	initial clash = 1'b0;

	// Input register fills whole word while selected
	always @* if (!cs_n) in_reg = rw ? conv_reg : db_out;

	// Load converter only on the select rising edge
	always @(posedge cs_n) if (!rw) conv_reg = in_reg;

	// Wire level; released bus shows the inverse of the last value
	always @* begin
		if (db_oe) db_in = db_out;
		else if (drv) db_in = in_reg;
		else db_in = ~last;
	end
	always @* if (db_oe || drv) last = db_in;

	// Both parties driving during a read window
	always @* if (db_oe && drv) clash = 1'b1;
endmodule : dacpl_dev_model

// [bench/testbench.sv]
// Self-checking bench for the converter load port controller
module testbench
	import dacpl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic              mclk    = 1'b0;
	logic              rst     = 1'b1;
	logic              ce      = 1'b1;
	logic              ce_drop = 1'b0;
	dacpl_req_t        req     = '0;
	logic              req_ready;
	logic              rsp_valid;
	logic [DATA_W-1:0] rsp_data;
	logic [DATA_W-1:0] db_in;
	logic [DATA_W-1:0] conv_reg;
	logic [DATA_W-1:0] last_wr = 12'h000;
	logic [DATA_W-1:0] w;
	logic [31:0]       r;
	logic              clash;
	dacpl_pins_t       pins;
	logic [DATA_W-1:0] exp_q[$];
	int                errors  = 0;
	int                n_tests = 0;
	int                cycles  = 0;

	// Clock
	always #25 mclk = ~mclk;

	dacpl_host dacpl_host_i (.mclk(mclk), .rst(rst), .ce(ce), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.pins(pins), .db_in(db_in));

	dacpl_dev_model dacpl_dev_model_i (.cs_n(pins.cs_n), .rw(pins.rw),
		.db_out(pins.db_out), .db_oe(pins.db_oe), .db_in(db_in),
		.conv_reg(conv_reg), .clash(clash));

	// Compare and count
	task automatic check(input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] want);
		n_tests++;
		if (seen !== want) begin
			errors++;
			$display("ERROR %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check

	// Verdict and end of run
	task automatic final_report;
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	// One request held until taken, expectation noted at the take
	task automatic xfer(input logic wr, input logic [DATA_W-1:0] d);
		@(negedge mclk);
		req <= '{valid: 1'b1, wr: wr, data: d};
		@(posedge mclk);
		while (req_ready !== 1'b1 || ce !== 1'b1) @(posedge mclk);
		if (wr) last_wr = d;
		exp_q.push_back(last_wr);
		@(negedge mclk);
		req.valid <= 1'b0;
	endtask : xfer

	// Response watcher takes the oldest note
	always @(posedge mclk) if (rsp_valid === 1'b1 && ce === 1'b1) begin
		w = exp_q.pop_front();
		check(rsp_data, w);
		check(conv_reg, w);
	end

	// Clock enable drops one cycle in four while a scenario asks for it
	always @(negedge mclk) ce <= !ce_drop || (cycles[1:0] != 2'b11);

	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			final_report;
		end
	end

	// Main sequence
	initial begin
		void'($urandom(32'hC7C93612));
		repeat (2) @(posedge mclk);
		@(negedge mclk) rst <= 1'b0;
		xfer(1'b0, 12'h000);
		xfer(1'b1, 12'hFFF);
		xfer(1'b0, 12'h000);
		xfer(1'b1, 12'h000);
		xfer(1'b1, 12'hA5C);
		xfer(1'b0, 12'hFFF);
		repeat (60) begin
			r = $urandom();
			ce_drop = r[13];
			xfer(r[12], r[11:0]);
		end
		ce_drop = 1'b0;
		repeat (10) @(posedge mclk);
		check({11'h000, clash}, 12'h000);
		check(12'(exp_q.size()), 12'h000);
		final_report;
	end
endmodule : testbench
